// ---- memory_mapper_mode_control_bench.sv ----
// self-checking bench: ahb-lite master, mapper model, mode and page tests
// assumes the default 8-bit page loading of the controller
`timescale 1ns/100ps
module memory_mapper_mode_control_bench;
    logic MCLK_I = 0, ARST_N_I = 0, HSEL_I = 0, HWRITE_I = 0, CE_I = 1;
    logic [31:0] HADDR_I = 0, HWDATA_I = 0, HRDATA_O, rd;
    logic [1:0] HTRANS_I = 0;
    logic [3:0] ti = 0, REGISTER_INDEX_O;
    logic HREADYOUT_O, HRESP_O, CS_N_O, MAP_MODE_N_O, STROBE_N_O, RW_O, OE_N, PAGE_DATA_OE_O, PROT_O, SEC_O;
    logic [11:0] PAGE_DATA_O, mdl_d, xlat;
    wire logic [11:0] pbus = PAGE_DATA_OE_O ? PAGE_DATA_O : mdl_d;
    int num_errors = 0, comparisons = 0;
    mmc_ctrl dut (.MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
        .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O),
        .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CS_N_O(CS_N_O),
        .MAP_MODE_N_O(MAP_MODE_N_O), .STROBE_N_O(STROBE_N_O), .RW_O(RW_O), .OUTPUT_ENABLE_N_O(OE_N),
        .REGISTER_INDEX_O(REGISTER_INDEX_O), .PAGE_DATA_O(PAGE_DATA_O), .PAGE_DATA_OE_O(PAGE_DATA_OE_O),
        .PAGE_DATA_I(pbus), .PROTECT_BLOCK_O(PROT_O), .SECOND_SELECT_O(SEC_O));
    mmc_mapper_model mdl (.clk_i(MCLK_I), .cs_n_i(CS_N_O), .map_mode_n_i(MAP_MODE_N_O), .strobe_n_i(STROBE_N_O),
        .rw_i(RW_O), .output_enable_n_i(OE_N), .register_index_i(REGISTER_INDEX_O), .translate_index_i(ti),
        .page_data_i(pbus), .page_data_o(mdl_d), .translated_address_o(xlat));
    // 10 MHz clock
    initial forever #50 MCLK_I = ~MCLK_I;
    // -----------------------------------------------------------
    // tasks
    // -----------------------------------------------------------
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one single transfer; the address phase is held until hready is seen
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge MCLK_I);
        HSEL_I <= 1'b1;
        HTRANS_I <= 2'h2;
        HADDR_I <= {24'h0, a};
        HWRITE_I <= wr;
        do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
        HSEL_I <= 1'b0;
        HTRANS_I <= 2'h0;
        HWDATA_I <= wd;
        do @(posedge MCLK_I); while (HREADYOUT_O !== 1'b1);
        rd = HRDATA_O;
    endtask
    // page command; a write goes as low byte, then the upper four bits
    task page(input logic wr, input logic [3:0] i, input logic [11:0] v);
        xfer(1'b1, mmc_pkg::PAGE_OFS, {10'h0, 1'b0, wr, i, 8'h00, v[7:0]});
        if (wr) xfer(1'b1, mmc_pkg::PAGE_OFS, {10'h0, 1'b1, 1'b1, i, 8'h00, 4'h0, v[11:8]});
        repeat (10) @(posedge MCLK_I);
    endtask
    task mode(input logic [31:0] w, input logic cs, input logic mm, input logic [1:0] st);
        xfer(1'b1, mmc_pkg::CTRL_OFS, w);
        repeat (4) @(posedge MCLK_I);
        check("cs_n", CS_N_O, cs);
        check("map_mode_n", MAP_MODE_N_O, mm);
        xfer(1'b0, mmc_pkg::STAT_OFS, 32'h0);
        check("stat mode", rd[1:0], st);
    endtask
    task readback(input logic [3:0] i, input logic [11:0] v);
        page(1'b0, i, 12'h000);
        xfer(1'b0, mmc_pkg::PAGE_OFS, 32'h0);
        check("page read", rd[11:0], v);
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // -----------------------------------------------------------
    // tests
    // -----------------------------------------------------------
    initial begin
        repeat (3) @(posedge MCLK_I);
        ARST_N_I <= 1'b1;
        check("reset cs_n", CS_N_O, 1'b1);
        check("reset map_mode_n", MAP_MODE_N_O, 1'b1);
        check("output enable", OE_N, 1'b0);
        xfer(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        mode(32'h0, 1'b1, 1'b1, mmc_pkg::MODE_PASS);
        $display("test reset done");
        mode(32'h6, 1'b0, 1'b1, mmc_pkg::MODE_IO);
        page(1'b1, 4'h5, 12'hA5C);
        page(1'b1, 4'hF, 12'h7E1);
        page(1'b1, 4'h0, 12'h303);
        check("reg 5", mdl.regs_q[5], 12'hA5C);
        check("reg 15", mdl.regs_q[15], 12'h7E1);
        check("reg 0", mdl.regs_q[0], 12'h303);
        xfer(1'b1, mmc_pkg::PROT_OFS, 32'h1);
        repeat (3) @(posedge MCLK_I);
        check("protect on", PROT_O, 1'b1);
        xfer(1'b1, mmc_pkg::PROT_OFS, 32'h0);
        repeat (3) @(posedge MCLK_I);
        check("protect off", PROT_O, 1'b0);
        readback(4'h5, 12'hA5C);
        readback(4'hF, 12'h7E1);
        $display("test access done");
        mode(32'h4, 1'b1, 1'b0, mmc_pkg::MODE_MAP);
        ti <= 4'h5;
        @(posedge MCLK_I);
        check("map output", xlat, 12'hA5C);
        page(1'b1, 4'h5, 12'h111);
        mode(32'hD, 1'b1, 1'b1, mmc_pkg::MODE_PASS);
        ti <= 4'h9;
        @(posedge MCLK_I);
        check("pass output", xlat, 12'h009);
        check("second select", SEC_O, 1'b1);
        mode(32'hF, 1'b1, 1'b1, mmc_pkg::MODE_PASS);
        mode(32'h6, 1'b0, 1'b1, mmc_pkg::MODE_IO);
        readback(4'h5, 12'hA5C);
        // frozen controller: a mode write while the enable is low must leave the pins alone
        CE_I <= 1'b0;
        xfer(1'b1, mmc_pkg::CTRL_OFS, 32'h4);
        repeat (4) @(posedge MCLK_I);
        check("frozen cs_n", CS_N_O, 1'b0);
        check("frozen map_mode_n", MAP_MODE_N_O, 1'b1);
        CE_I <= 1'b1;
        $display("test modes done");
        // two edges in reset so the checker's history holds only reset values at release
        ARST_N_I <= 1'b0;
        repeat (2) @(posedge MCLK_I);
        check("mid reset cs_n", CS_N_O, 1'b1);
        check("mid reset map_mode_n", MAP_MODE_N_O, 1'b1);
        ARST_N_I <= 1'b1;
        mode(32'h0, 1'b1, 1'b1, mmc_pkg::MODE_PASS);
        $display("test second reset done");
        print_verdict();
    end
    // hang guard, well beyond the few hundred cycles the tests take
    initial begin
        repeat (5000) @(posedge MCLK_I);
        num_errors++;
        print_verdict();
    end
endmodule

// ---- mmc_ctrl.sv ----
// controller for a 16 x 12 bit address mapper, driven over ahb-lite
// assumes the mapper pins are sampled by a synchronous board on MCLK_I
`timescale 1ns/100ps
module mmc_ctrl #(
    parameter int PAGE_W = 12,
    parameter int IDX_W = 4,
    parameter int BUS_W = 8
) (
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    input wire logic CE_I,
    // ahb-lite slave
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic [31:0] HRDATA_O,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    // mapper pins
    output logic CS_N_O,
    output logic MAP_MODE_N_O,
    output logic STROBE_N_O,
    output logic RW_O,
    output logic OUTPUT_ENABLE_N_O,
    output logic [IDX_W-1:0] REGISTER_INDEX_O,
    output logic [PAGE_W-1:0] PAGE_DATA_O,
    output logic PAGE_DATA_OE_O,
    input wire logic [PAGE_W-1:0] PAGE_DATA_I,
    // protection strobe gate and second mapper select
    output logic PROTECT_BLOCK_O,
    output logic SECOND_SELECT_O
);
    // refuse geometries that the page assembly below cannot serve
    // checked at elaboration so a bad build never reaches the bench
    if (PAGE_W != 12 || IDX_W != 4 || (BUS_W != 8 && BUS_W != 16)) begin : g_bad_geometry
        $error("unsupported mapper geometry");
    end

    // ----------------------------------------
    // ahb address phase capture
    // ----------------------------------------
    logic ph_q;
    logic ph_wr_q;
    logic [7:0] ph_addr_q;
    wire logic take = HSEL_I & HREADY_I & HTRANS_I[1];
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ph_q <= 1'b0;
            ph_wr_q <= 1'b0;
            ph_addr_q <= 8'h00;
        end else if (CE_I) begin
            if (HREADYOUT_O || take) begin
                ph_q <= take;
                ph_wr_q <= HWRITE_I;
                ph_addr_q <= HADDR_I[7:0];
            end
        end
    end

    // ----------------------------------------
    // controller registers
    // ----------------------------------------
    logic [1:0] mode_wr_q;
    logic mode_load_q;
    logic serial_q;
    logic second_q;
    logic [1:0] prot_q;
    logic [PAGE_W-1:0] page_q;
    logic [IDX_W-1:0] idx_q;
    logic cmd_wr_q;
    logic go_q;
    logic busy_q;
    logic lo_half_q;
    logic [PAGE_W-1:0] rd_q;
    wire logic wr_now = ph_q & ph_wr_q & HREADYOUT_O;
    wire logic [1:0] cur_mode = {~CS_N_O, MAP_MODE_N_O & CS_N_O};
    // mode writes go through the flip-flop pair only on a decoded write
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            mode_wr_q <= mmc_pkg::MODE_RST;
            mode_load_q <= 1'b0;
            serial_q <= 1'b0;
            second_q <= 1'b0;
            prot_q <= 2'h0;
        end else if (CE_I) begin
            mode_load_q <= 1'b0;
            if (wr_now && ph_addr_q == mmc_pkg::CTRL_OFS) begin
                mode_wr_q <= HWDATA_I[mmc_pkg::CTRL_MODE_LSB +: 2];
                mode_load_q <= 1'b1;
                serial_q <= HWDATA_I[mmc_pkg::CTRL_SERIAL_BIT];
                second_q <= HWDATA_I[mmc_pkg::CTRL_SECOND_BIT];
            end
            if (wr_now && ph_addr_q == mmc_pkg::PROT_OFS) begin
                prot_q <= HWDATA_I[1:0];
            end
        end
    end
    // page command: on a narrow bus the 12 bits assemble from two writes
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            page_q <= '0;
            idx_q <= '0;
            cmd_wr_q <= 1'b0;
            go_q <= 1'b0;
            lo_half_q <= 1'b0;
        end else if (CE_I) begin
            go_q <= 1'b0;
            if (wr_now && ph_addr_q == mmc_pkg::PAGE_OFS && !busy_q && !go_q) begin
                idx_q <= HWDATA_I[mmc_pkg::PAGE_IDX_LSB +: IDX_W];
                cmd_wr_q <= HWDATA_I[mmc_pkg::PAGE_WR_BIT];
                if (BUS_W == 16) begin
                    page_q <= HWDATA_I[PAGE_W-1:0];
                    go_q <= 1'b1;
                end else if (!HWDATA_I[mmc_pkg::PAGE_HALF_BIT]) begin
                    page_q[7:0] <= HWDATA_I[7:0];
                    lo_half_q <= 1'b1;
                    go_q <= ~HWDATA_I[mmc_pkg::PAGE_WR_BIT];
                end else begin
                    page_q[PAGE_W-1:8] <= HWDATA_I[PAGE_W-9:0];
                    lo_half_q <= 1'b0;
                    go_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // mode pair and pin sequencer
    // ----------------------------------------
    mmc_pin_drv u_pins (
        .clk_i(MCLK_I),
        .rst_n_i(ARST_N_I),
        .ce_i(CE_I),
        .load_i(mode_load_q & serial_q),
        .data_i(mode_wr_q),
        .io_force_i(busy_q),
        .map_mode_n_o(MAP_MODE_N_O),
        .cs_n_o(CS_N_O)
    );

    mmc_pkg::mmc_state_e st_q;
    logic [1:0] cnt_q;
    // strobe sequence; only strobe, direction and data enable move while in access mode
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            st_q <= mmc_pkg::ST_IDLE;
            cnt_q <= 2'h0;
            busy_q <= 1'b0;
            STROBE_N_O <= 1'b1;
            RW_O <= 1'b1;
            PAGE_DATA_OE_O <= 1'b0;
            rd_q <= '0;
        end else if (CE_I) begin
            case (st_q)
                mmc_pkg::ST_IDLE: begin
                    if (go_q && !CS_N_O) begin
                        busy_q <= 1'b1;
                        RW_O <= ~cmd_wr_q;
                        PAGE_DATA_OE_O <= cmd_wr_q;
                        st_q <= mmc_pkg::ST_SETUP;
                    end
                end
                mmc_pkg::ST_SETUP: begin
                    STROBE_N_O <= ~cmd_wr_q;
                    cnt_q <= 2'(mmc_pkg::STROBE_CYC + mmc_pkg::ACCESS_CYC - 1);
                    st_q <= mmc_pkg::ST_STROBE;
                end
                mmc_pkg::ST_STROBE: begin
                    if (cnt_q == 2'h0) begin
                        STROBE_N_O <= 1'b1;
                        rd_q <= PAGE_DATA_I;
                        st_q <= mmc_pkg::ST_HOLD;
                    end else begin
                        cnt_q <= cnt_q - 2'h1;
                    end
                end
                mmc_pkg::ST_HOLD: begin
                    RW_O <= 1'b1;
                    PAGE_DATA_OE_O <= 1'b0;
                    busy_q <= 1'b0;
                    st_q <= mmc_pkg::ST_IDLE;
                end
                default: st_q <= mmc_pkg::ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // registered pin drive and bus answers
    // ----------------------------------------
    // output enable held active: the mapper outputs are always driving
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            OUTPUT_ENABLE_N_O <= 1'b0;
            REGISTER_INDEX_O <= '0;
            PAGE_DATA_O <= '0;
            PROTECT_BLOCK_O <= 1'b0;
            SECOND_SELECT_O <= 1'b0;
        end else if (CE_I) begin
            OUTPUT_ENABLE_N_O <= 1'b0;
            REGISTER_INDEX_O <= idx_q;
            PAGE_DATA_O <= page_q;
            PROTECT_BLOCK_O <= |(prot_q & page_q[1:0]);
            SECOND_SELECT_O <= second_q;
        end
    end
    // reads answer in the cycle after the address phase
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            HRDATA_O <= 32'h0000_0000;
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
        end else if (CE_I) begin
            HREADYOUT_O <= 1'b1;
            HRESP_O <= 1'b0;
            HRDATA_O <= 32'h0000_0000;
            if (take && !HWRITE_I) begin
                case (HADDR_I[7:0])
                    mmc_pkg::CTRL_OFS: HRDATA_O <= {28'h0, second_q, serial_q, mode_wr_q};
                    mmc_pkg::PAGE_OFS: HRDATA_O <= {20'h0, rd_q};
                    mmc_pkg::STAT_OFS: HRDATA_O <= {27'h0, lo_half_q, busy_q, 1'b0, cur_mode};
                    mmc_pkg::PROT_OFS: HRDATA_O <= {30'h0, prot_q};
                    default: HRDATA_O <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

// ---- mmc_mapper_model.sv ----
// behavioural model of the 16 x 12 address mapper at the controller's pins
// assumes pins are sampled on the controller clock; one driver per data line
`timescale 1ns/100ps
module mmc_mapper_model (
    // clock
    input wire logic clk_i,
    // control pins
    input wire logic cs_n_i,
    input wire logic map_mode_n_i,
    input wire logic strobe_n_i,
    input wire logic rw_i,
    input wire logic output_enable_n_i,
    input wire logic [3:0] register_index_i,
    input wire logic [3:0] translate_index_i,
    // data lines
    input wire logic [11:0] page_data_i,
    output logic [11:0] page_data_o,
    output logic [11:0] translated_address_o
);
    logic [11:0] regs_q [16];
    logic [11:0] last_q = 12'h000;
    // load on chip select, strobe and direction all low
    always_ff @(posedge clk_i) begin
        if (!cs_n_i && !strobe_n_i && !rw_i) begin
            regs_q[register_index_i] <= page_data_i;
        end
        last_q <= page_data_o;
    end
    // released lines show the inverse of the last value, never a held copy
    assign page_data_o = (!cs_n_i && rw_i) ? regs_q[register_index_i] : ~last_q;
    // map output: tri-state when disabled, page in map mode, index in pass mode
    assign translated_address_o = output_enable_n_i ? 12'hZZZ :
        (!map_mode_n_i && cs_n_i) ? regs_q[translate_index_i] :
        {8'h00, translate_index_i};
endmodule

// ---- mmc_monitor.sv ----
// concurrent checks on the mapper controller's top ports
// assumes one clock domain and the bind below
`timescale 1ns/100ps
module mmc_monitor #(
    parameter int PAGE_W = 12,
    parameter int IDX_W = 4,
    parameter int BUS_W = 8
) (
    // clock and reset
    input wire logic MCLK_I,
    input wire logic ARST_N_I,
    // bus side
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    // mapper pins
    input wire logic CS_N_O,
    input wire logic MAP_MODE_N_O,
    input wire logic STROBE_N_O,
    input wire logic RW_O,
    input wire logic OUTPUT_ENABLE_N_O,
    input wire logic PAGE_DATA_OE_O
);
    logic aph_q;
    logic ctrl_dp;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    // -----------------------------------------------------------
    // helper: data phase of a mode write with the serial bit set
    // -----------------------------------------------------------
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            aph_q <= 1'b0;
        end else begin
            aph_q <= HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I && (HADDR_I[7:0] == mmc_pkg::CTRL_OFS);
        end
    end
    assign ctrl_dp = aph_q && HWDATA_I[mmc_pkg::CTRL_SERIAL_BIT];
    // -----------------------------------------------------------
    // assertions
    // -----------------------------------------------------------
    AST_ONE_MODE: assert property (!(!CS_N_O && !MAP_MODE_N_O))
        else $error("chip select and map mode low together");
    AST_MM_IN_ACCESS: assert property (!RW_O |-> MAP_MODE_N_O)
        else $error("map mode low during register access");
    AST_OE_TIED: assert property (OUTPUT_ENABLE_N_O == 1'b0)
        else $error("map output enable not active");
    AST_WRITE_QUAL: assert property (!STROBE_N_O |-> !CS_N_O && !RW_O && PAGE_DATA_OE_O)
        else $error("strobe without write qualifiers");
    AST_RW_BEFORE: assert property ($fell(STROBE_N_O) |-> $past(!RW_O))
        else $error("direction not set before strobe");
    AST_STROBE_LEN: assert property ($fell(STROBE_N_O) |=> !STROBE_N_O ##1 STROBE_N_O)
        else $error("strobe low time wrong");
    AST_READ_FREE: assert property (RW_O |-> !PAGE_DATA_OE_O)
        else $error("data driven during read");
    AST_NO_WAIT: assert property (HREADYOUT_O && !HRESP_O)
        else $error("wait state or error response");
    AST_MODE_HOLD: assert property ($changed({CS_N_O, MAP_MODE_N_O}) |-> $past(ctrl_dp, 2) || $past(ctrl_dp, 3))
        else $error("mode pins changed without mode write");
    COV_STROBE: cover property ($fell(STROBE_N_O));
    COV_MAP: cover property ($fell(MAP_MODE_N_O));
    COV_ACCESS: cover property ($fell(CS_N_O));
endmodule
bind mmc_ctrl mmc_monitor #(.PAGE_W(PAGE_W), .IDX_W(IDX_W), .BUS_W(BUS_W)) u_mon (.MCLK_I(MCLK_I),
    .ARST_N_I(ARST_N_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
    .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .CS_N_O(CS_N_O),
    .MAP_MODE_N_O(MAP_MODE_N_O), .STROBE_N_O(STROBE_N_O), .RW_O(RW_O), .OUTPUT_ENABLE_N_O(OUTPUT_ENABLE_N_O),
    .PAGE_DATA_OE_O(PAGE_DATA_OE_O));

// ---- mmc_pin_drv.sv ----
// two mode flip-flops that feed map mode and chip select
// assumes a qualified write pulse from the controller
`timescale 1ns/100ps
module mmc_pin_drv (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // load
    input wire logic load_i,
    input wire logic [1:0] data_i,
    input wire logic io_force_i,
    // pins
    output logic map_mode_n_o,
    output logic cs_n_o
);
    logic [1:0] mode_q;
    // ----------------------------------------
    // mode pair, loaded with MODE_RST (pass) by system reset
    // ----------------------------------------
    // bit0 high alone = pass, bit1 high alone = access, both low = map
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_q <= mmc_pkg::MODE_RST;
        end else if (ce_i && load_i) begin
            if (data_i != 2'h3) begin
                mode_q <= data_i;
            end
        end
    end
    // pins from flops; access mode keeps map mode high so memory is untouched
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            map_mode_n_o <= 1'b1;
            cs_n_o <= 1'b1;
        end else if (ce_i) begin
            map_mode_n_o <= mode_q[0] | mode_q[1] | io_force_i;
            cs_n_o <= ~mode_q[1];
        end
    end
endmodule

// ---- mmc_pkg.sv ----
// package for the memory mapper mode controller
// assumes one clock domain; used by mmc_ctrl and mmc_pin_drv
package mmc_pkg;
    // ----------------------------------------
    // register map of the controller (word offsets in bytes)
    // ----------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] PAGE_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [7:0] PROT_OFS = 8'h0C;
    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SERIAL_BIT = 2;
    localparam int CTRL_SECOND_BIT = 3;
    // page command fields
    localparam int PAGE_DATA_LSB = 0;
    localparam int PAGE_IDX_LSB = 16;
    localparam int PAGE_WR_BIT = 20;
    localparam int PAGE_HALF_BIT = 21;
    // reset values
    localparam logic [1:0] MODE_RST = 2'h1;
    // ----------------------------------------
    // mode codes: bit0 = pass, bit1 = register access
    // ----------------------------------------
    localparam logic [1:0] MODE_MAP = 2'h0;
    localparam logic [1:0] MODE_PASS = 2'h1;
    localparam logic [1:0] MODE_IO = 2'h2;
    // timing: pin strobe low time and access time
    localparam int STROBE_NS = 100;
    localparam int CLK_NS = 100;
    localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS = 75;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;

    typedef enum {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD} mmc_state_e;

    // mapper control pins as one bundle
    typedef struct packed {
        logic cs_n;
        logic map_mode_n;
        logic strobe_n;
        logic rw;
    } mmc_pins_s;
endpackage
